// ==== hw/omc_pkg.sv ====
// constants, state codes and carriers of the operating-mode controller
// assumes a single 50 MHz clock; slow-oscillator rate is modelled by an enable divider
package omc_pkg;
  // ==========================================================================
  // clock rates and warm-up counts
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int unsigned FAST_WARM_EXP = 19;
  localparam int unsigned SLOW_WARM_EXP = 13;
  localparam int unsigned WARM_LONG_MULT = 3;
  localparam int unsigned FAST_WARM_SHORT = 2 ** FAST_WARM_EXP;
  localparam int unsigned FAST_WARM_LONG = WARM_LONG_MULT * FAST_WARM_SHORT;
  localparam int unsigned SLOW_WARM_SHORT = 2 ** SLOW_WARM_EXP;
  localparam int unsigned SLOW_WARM_LONG = WARM_LONG_MULT * SLOW_WARM_SHORT;
  localparam int unsigned DIV_W = 21;

  // ==========================================================================
  // register offsets, bit positions, reset values
  localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
  localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int unsigned C1_STOP = 7;
  localparam int unsigned C1_WAKE_LEVEL = 6;
  localparam int unsigned C1_RET_SLOW = 5;
  localparam int unsigned C1_PORT_DRIVE = 4;
  localparam int unsigned C1_WARM_LO = 2;
  localparam int unsigned C2_FAST_EN = 7;
  localparam int unsigned C2_SLOW_EN = 6;
  localparam int unsigned C2_CLK_SLOW = 5;
  localparam int unsigned C2_IDLE = 4;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [1:0] WARM_SEL_LONG = 2'h0;

  // ==========================================================================
  // sequencer states and reported operating modes
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_stop = 2'b01,
    st_warm = 2'b10,
    st_idle = 2'b11
  } omc_state_t;

  typedef enum logic [3:0] {
    m_fast_only_run = 4'b0000,
    m_dual_clock_run = 4'b0001,
    m_slow_run = 4'b0010,
    m_fast_only_doze = 4'b0011,
    m_dual_clock_doze = 4'b0100,
    m_sleep_doze = 4'b0101,
    m_halt_variant_a = 4'b0110,
    m_halt_variant_b = 4'b0111,
    m_warmup = 4'b1000
  } omc_mode_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } omc_bus_req_t;

  typedef struct packed {
    logic master_int_flag;
    logic wdt_pending;
    logic ext_irq_zero;
    logic [11:0] pending_latch;
    logic [11:0] source_int_enable;
  } omc_irq_t;

  typedef struct packed {
    logic fast_run;
    logic slow_run;
    logic cpu_on_slow;
  } omc_osc_t;
endpackage : omc_pkg

// ==== hw/omc_mode_ctrl.sv ====
// operating-mode controller: stop, warm-up, idle and slow/fast clock switching
// assumes cpu, watchdog and interrupt controller sit beside it on ref_clk;
// the stop and reset pins are asynchronous and are synchronised here
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module omc_mode_ctrl #(
  parameter int unsigned WARM_FAST_LONG = omc_pkg::FAST_WARM_LONG,
  parameter int unsigned WARM_FAST_SHORT = omc_pkg::FAST_WARM_SHORT,
  parameter int unsigned WARM_SLOW_LONG = omc_pkg::SLOW_WARM_LONG,
  parameter int unsigned WARM_SLOW_SHORT = omc_pkg::SLOW_WARM_SHORT,
  parameter int unsigned SLOW_TICK_DIV = omc_pkg::SLOW_DIV,
  parameter bit SLOW_OSC_AT_RESET = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins
  input wire logic stop_pin,
  input wire logic reset_pin_n,
  // register port
  input wire omc_pkg::omc_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  // interrupt controller
  input wire omc_pkg::omc_irq_t irq,
  output logic int_service_req,
  // cpu and system control
  output logic chip_reset,
  output logic cpu_halt,
  output logic wdt_halt,
  output logic periph_halt,
  output logic resume,
  output logic port_hiz,
  output logic bank_select_lost,
  output omc_pkg::omc_osc_t osc,
  output logic [omc_pkg::DIV_W-1:0] timing_div_q,
  output omc_pkg::omc_mode_t mode_q
);

  // ==========================================================================
  // elaboration checks
  if (WARM_FAST_LONG < 2 || WARM_FAST_SHORT < 2 || WARM_SLOW_LONG < 2 || WARM_SLOW_SHORT < 2
      || WARM_FAST_LONG > 2 ** omc_pkg::DIV_W || WARM_SLOW_LONG > 2 ** omc_pkg::DIV_W
      || SLOW_TICK_DIV < 2 || SLOW_TICK_DIV > 65535)
  begin : g_bad_param
    $error("omc_mode_ctrl: warm-up or divider parameter out of range");
  end

  // ==========================================================================
  // declarations
  omc_pkg::omc_state_t state_q;
  logic stop_meta_q, stop_sync_q, stop_prev_q, stop_rise;
  logic rpin_meta_q, rpin_sync_q;
  logic sys_rst;
  logic wake_level_sel_q, ret_slow_q, port_drive_q;
  logic [1:0] warm_sel_q;
  logic level_eff_q, level_pend_q;
  logic fast_en_q, slow_en_q, sel_slow_q, cpu_on_slow_q;
  logic warm_slow_q, warm_done, div_tick;
  logic [15:0] slow_cnt_q;
  logic slow_tick;
  logic [omc_pkg::DIV_W-1:0] warm_last;
  logic wr_one, wr_two, stop_req, idle_req, idle_wake, stop_wake, skip_stop;
  logic dual;
  omc_pkg::omc_mode_t mode_d;

  assign dual = slow_en_q;
  assign wr_one = bus_req.wr && bus_req.addr == omc_pkg::ADDR_CTRL_ONE;
  assign wr_two = bus_req.wr && bus_req.addr == omc_pkg::ADDR_CTRL_TWO;
  assign stop_req = wr_one && bus_req.wdata[omc_pkg::C1_STOP] && state_q == omc_pkg::st_run;
  assign idle_req = wr_two && bus_req.wdata[omc_pkg::C2_IDLE] && state_q == omc_pkg::st_run;

  // ==========================================================================
  // pin synchronisers; first stage is read only by the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stop_meta_q <= 1'b0;
      stop_sync_q <= 1'b0;
      stop_prev_q <= 1'b0;
      rpin_meta_q <= 1'b1;
      rpin_sync_q <= 1'b1;
    end
    else
    begin
      stop_meta_q <= stop_pin;
      stop_sync_q <= stop_meta_q;
      stop_prev_q <= stop_sync_q;
      rpin_meta_q <= reset_pin_n;
      rpin_sync_q <= rpin_meta_q;
    end
  end

  assign stop_rise = stop_sync_q && !stop_prev_q;
  // the pin reset acts in any state, stop and idle included
  assign sys_rst = rst || !rpin_sync_q;
  assign chip_reset = !rpin_sync_q;

  // ==========================================================================
  // control-one fields retained through stop
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wake_level_sel_q <= omc_pkg::CTRL_ONE_RST[omc_pkg::C1_WAKE_LEVEL];
      ret_slow_q <= omc_pkg::CTRL_ONE_RST[omc_pkg::C1_RET_SLOW];
      port_drive_q <= omc_pkg::CTRL_ONE_RST[omc_pkg::C1_PORT_DRIVE];
      warm_sel_q <= omc_pkg::CTRL_ONE_RST[omc_pkg::C1_WARM_LO +: 2];
    end
    else if (wr_one)
    begin
      wake_level_sel_q <= bus_req.wdata[omc_pkg::C1_WAKE_LEVEL];
      ret_slow_q <= bus_req.wdata[omc_pkg::C1_RET_SLOW];
      port_drive_q <= bus_req.wdata[omc_pkg::C1_PORT_DRIVE];
      warm_sel_q <= bus_req.wdata[omc_pkg::C1_WARM_LO +: 2];
    end
  end

  // ==========================================================================
  // effective wake style; a move to level waits for a rising pin edge
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      level_eff_q <= 1'b0;
      level_pend_q <= 1'b0;
    end
    else if (wr_one && !bus_req.wdata[omc_pkg::C1_WAKE_LEVEL])
    begin
      level_eff_q <= 1'b0;
      level_pend_q <= 1'b0;
    end
    else if (level_pend_q && stop_rise)
    begin
      level_eff_q <= 1'b1;
      level_pend_q <= 1'b0;
    end
    else if (wr_one && !level_eff_q)
    begin
      level_pend_q <= 1'b1; // a rewrite never hides a coinciding edge
    end
  end

  // ==========================================================================
  // slow-oscillator rate as an enable pulse; counter held at zero while that oscillator is off
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !osc.slow_run)
      slow_cnt_q <= 16'h0000;
    else if (slow_tick)
      slow_cnt_q <= 16'h0000;
    else
      slow_cnt_q <= slow_cnt_q + 16'h0001;
  end

  assign slow_tick = osc.slow_run && slow_cnt_q == 16'(SLOW_TICK_DIV - 1);

  // ==========================================================================
  // warm-up terminal and wake conditions
  always_comb
  begin
    if (warm_slow_q)
      warm_last = (warm_sel_q == omc_pkg::WARM_SEL_LONG) ? omc_pkg::DIV_W'(WARM_SLOW_LONG - 1)
                                                         : omc_pkg::DIV_W'(WARM_SLOW_SHORT - 1);
    else
      warm_last = (warm_sel_q == omc_pkg::WARM_SEL_LONG) ? omc_pkg::DIV_W'(WARM_FAST_LONG - 1)
                                                         : omc_pkg::DIV_W'(WARM_FAST_SHORT - 1);
  end

  // divider steps on the clock of the restarted oscillator
  assign div_tick = warm_slow_q ? slow_tick : 1'b1;
  assign warm_done = state_q == omc_pkg::st_warm && div_tick && timing_div_q == warm_last;
  assign stop_wake = level_eff_q ? stop_sync_q : stop_rise;
  assign skip_stop = level_eff_q && stop_sync_q;
  assign idle_wake = irq.ext_irq_zero || |(irq.pending_latch & irq.source_int_enable);

  // ==========================================================================
  // sequencer
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_q <= omc_pkg::st_run;
    else
      case (state_q)
        omc_pkg::st_run:
          if (stop_req)
            state_q <= skip_stop ? omc_pkg::st_warm : omc_pkg::st_stop;
          else if (idle_req && !irq.wdt_pending)
            state_q <= omc_pkg::st_idle;
        omc_pkg::st_stop:
          if (stop_wake)
            state_q <= omc_pkg::st_warm;
        omc_pkg::st_warm:
          if (warm_done)
            state_q <= omc_pkg::st_run;
        omc_pkg::st_idle:
          if (idle_wake)
            state_q <= omc_pkg::st_run;
        default:
          state_q <= omc_pkg::st_run;
      endcase
  end

  // warm-up clock choice is taken when the oscillators restart
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      warm_slow_q <= 1'b0;
    else if ((stop_req && skip_stop) || (state_q == omc_pkg::st_stop && stop_wake))
      warm_slow_q <= dual && ret_slow_q;
  end

  // ==========================================================================
  // timing-generator divider; cleared at stop entry and again before resuming
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      timing_div_q <= '0;
    else if (stop_req || warm_done)
      timing_div_q <= '0;
    else if (state_q == omc_pkg::st_stop)
      timing_div_q <= '0;
    else if (state_q == omc_pkg::st_warm)
    begin
      if (div_tick)
        timing_div_q <= timing_div_q + 1'b1;
    end
    else
      timing_div_q <= timing_div_q + 1'b1;
  end

  // ==========================================================================
  // oscillator enables and clock select; stop release rewrites all but the slow enable
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fast_en_q <= 1'b1;
      slow_en_q <= SLOW_OSC_AT_RESET;
      sel_slow_q <= 1'b0;
      cpu_on_slow_q <= 1'b0;
    end
    else if ((stop_req && skip_stop) || (state_q == omc_pkg::st_stop && stop_wake))
    begin
      fast_en_q <= !(dual && ret_slow_q);
      sel_slow_q <= dual && ret_slow_q;
      cpu_on_slow_q <= dual && ret_slow_q;
    end
    else if (wr_two && state_q == omc_pkg::st_run)
    begin
      fast_en_q <= bus_req.wdata[omc_pkg::C2_FAST_EN];
      slow_en_q <= bus_req.wdata[omc_pkg::C2_SLOW_EN];
      sel_slow_q <= bus_req.wdata[omc_pkg::C2_CLK_SLOW];
      if (bus_req.wdata[omc_pkg::C2_CLK_SLOW])
        cpu_on_slow_q <= 1'b1;
    end
    else if (!sel_slow_q && cpu_on_slow_q && fast_en_q && slow_tick)
      cpu_on_slow_q <= 1'b0;
  end

  // both oscillators stop in stop mode; one driver keeps the carrier whole
  assign osc = '{fast_run: fast_en_q && state_q != omc_pkg::st_stop,
                 slow_run: slow_en_q && state_q != omc_pkg::st_stop,
                 cpu_on_slow: cpu_on_slow_q};

  // ==========================================================================
  // halts, port control and resume pulses
  assign cpu_halt = state_q != omc_pkg::st_run;
  assign wdt_halt = state_q != omc_pkg::st_run;
  assign periph_halt = state_q == omc_pkg::st_stop || state_q == omc_pkg::st_warm;
  assign port_hiz = periph_halt && !port_drive_q;
  assign bank_select_lost = state_q == omc_pkg::st_stop;
  assign resume = warm_done || (state_q == omc_pkg::st_idle && idle_wake && !irq.master_int_flag);
  assign int_service_req = (state_q == omc_pkg::st_idle && idle_wake && irq.master_int_flag)
                           || (idle_req && irq.wdt_pending);

  // ==========================================================================
  // reported mode
  always_comb
  begin
    case (state_q)
      omc_pkg::st_stop:
        mode_d = dual ? omc_pkg::m_halt_variant_b : omc_pkg::m_halt_variant_a;
      omc_pkg::st_warm:
        mode_d = omc_pkg::m_warmup;
      omc_pkg::st_idle:
        mode_d = !dual ? omc_pkg::m_fast_only_doze
               : cpu_on_slow_q ? omc_pkg::m_sleep_doze : omc_pkg::m_dual_clock_doze;
      default:
        mode_d = !dual ? omc_pkg::m_fast_only_run
               : cpu_on_slow_q ? omc_pkg::m_slow_run : omc_pkg::m_dual_clock_run;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      mode_q <= omc_pkg::m_fast_only_run;
    else
      mode_q <= mode_d;
  end

  // ==========================================================================
  // register reads, answered one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (bus_req.rd)
      case (bus_req.addr)
        omc_pkg::ADDR_CTRL_ONE:
          rdata_q <= {state_q == omc_pkg::st_stop || state_q == omc_pkg::st_warm, wake_level_sel_q,
                      ret_slow_q, port_drive_q, warm_sel_q, 2'h0};
        omc_pkg::ADDR_CTRL_TWO:
          rdata_q <= {fast_en_q, slow_en_q, cpu_on_slow_q, state_q == omc_pkg::st_idle, 4'h0};
        omc_pkg::ADDR_STATUS:
          rdata_q <= {level_eff_q, level_pend_q, state_q, mode_q};
        default:
          rdata_q <= 8'h00;
      endcase
    else
      rdata_q <= 8'h00;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_stop_osc_off: assert property (state_q == omc_pkg::st_stop |-> !osc.fast_run && !osc.slow_run)
    else $error("oscillator running in stop");
  a_stop_entry: assert property (stop_req && !skip_stop |=> state_q == omc_pkg::st_stop && timing_div_q == '0)
    else $error("stop entry did not halt and clear divider");
  a_level_skip: assert property (stop_req && skip_stop |=> state_q == omc_pkg::st_warm)
    else $error("level wake with high pin did not skip stop");
  a_edge_wake: assert property (state_q == omc_pkg::st_stop && !level_eff_q && stop_rise |=> state_q == omc_pkg::st_warm)
    else $error("rising edge did not end stop");
  a_edge_hold: assert property (state_q == omc_pkg::st_stop && !level_eff_q && !stop_rise |=> state_q == omc_pkg::st_stop)
    else $error("stop ended without rising edge");
  a_level_wait: assert property (level_pend_q && !stop_rise |=> !level_eff_q)
    else $error("level style took effect before edge");
  a_warm_resume: assert property (warm_done |-> resume ##1 (state_q == omc_pkg::st_run && timing_div_q == '0))
    else $error("warm-up end did not resume with cleared divider");
  a_port_float: assert property (state_q == omc_pkg::st_stop |-> port_hiz == !port_drive_q)
    else $error("port float control wrong in stop");
  a_idle_wake: assert property (state_q == omc_pkg::st_idle && idle_wake |-> (resume == !irq.master_int_flag && int_service_req == irq.master_int_flag) ##1 state_q == omc_pkg::st_run)
    else $error("idle wake handled wrongly");
  a_wdt_block: assert property (idle_req && irq.wdt_pending |-> int_service_req ##1 state_q == omc_pkg::st_run)
    else $error("idle entered over watchdog interrupt");
  a_slow_switch: assert property ($fell(sel_slow_q) && state_q == omc_pkg::st_run |-> cpu_on_slow_q)
    else $error("cpu left slow clock before switch-over");
  a_idle_halt: assert property (state_q == omc_pkg::st_idle |-> cpu_halt && wdt_halt && !periph_halt)
    else $error("idle halt outputs wrong");

  c_stop_cycle: cover property (state_q == omc_pkg::st_stop ##1 state_q == omc_pkg::st_warm);
  c_idle_service: cover property (state_q == omc_pkg::st_idle && idle_wake && irq.master_int_flag);
  c_level_switch: cover property ($fell(level_pend_q) && level_eff_q);
  c_slow_back: cover property ($fell(cpu_on_slow_q));

endmodule : omc_mode_ctrl

`default_nettype wire

// ==== bench/omc_far_side.sv ====
// far-side model: interrupt latches, stop pin and reset pin of the controller
// assumes the bench drives its request inputs by nonblocking assignment at ref_clk
`timescale 1ns/1ps
`default_nettype none

module omc_far_side (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench requests: flags are master flag, watchdog pending, external zero
  input wire logic [11:0] raise_src,
  input wire logic load_en,
  input wire logic [11:0] load_val,
  input wire logic [2:0] flags,
  input wire logic [11:0] enables,
  input wire logic stop_level,
  input wire logic reset_low,
  // towards the controller
  output var omc_pkg::omc_irq_t irq,
  output logic stop_pin,
  output logic reset_pin_n
);
  logic [11:0] latch_q;
  // a plain load only clears latches; requests are the only way to set them
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      latch_q <= 12'h000;
    else
      latch_q <= (load_en ? latch_q & load_val : latch_q) | raise_src;
  end
  // pins move only at the clock so the two-flop sync latency stays fixed
  always_ff @(posedge ref_clk)
  begin
    stop_pin <= stop_level;
    reset_pin_n <= ~reset_low;
  end
  assign irq = {flags, latch_q, enables};
endmodule : omc_far_side

`default_nettype wire

// ==== bench/omc_mode_ctrl_test.sv ====
// self-checking bench of the operating-mode controller: stop, warm-up, idle, clock switch
// assumes omc_pkg compiled first and shortened warm-up counts
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module omc_mode_ctrl_test;
  localparam int FL = 12, FS = 4, SS = 2, DV = 4;
  logic ref_clk, rst, stop_pin, reset_pin_n, int_service_req, chip_reset, cpu_halt, wdt_halt, periph_halt;
  logic resume, port_hiz, bank_select_lost, load_en, stop_level, reset_low, svc;
  logic [7:0] rdata_q, d;
  logic [11:0] raise_src, load_val, enables;
  logic [2:0] flags;
  logic [omc_pkg::DIV_W-1:0] timing_div_q;
  omc_pkg::omc_bus_req_t req;
  omc_pkg::omc_irq_t irq;
  omc_pkg::omc_osc_t osc, wosc;
  omc_pkg::omc_mode_t mode_q;
  int n_errors = 0, n_compared = 0, w, r, s, cycles = 0;

  omc_mode_ctrl #(.WARM_FAST_LONG(FL), .WARM_FAST_SHORT(FS), .WARM_SLOW_LONG(6), .WARM_SLOW_SHORT(SS),
    .SLOW_TICK_DIV(DV)) omc_mode_ctrl_i (.ref_clk(ref_clk), .rst(rst), .stop_pin(stop_pin),
    .reset_pin_n(reset_pin_n), .bus_req(req), .rdata_q(rdata_q), .irq(irq), .int_service_req(int_service_req),
    .chip_reset(chip_reset), .cpu_halt(cpu_halt), .wdt_halt(wdt_halt), .periph_halt(periph_halt),
    .resume(resume), .port_hiz(port_hiz), .bank_select_lost(bank_select_lost), .osc(osc),
    .timing_div_q(timing_div_q), .mode_q(mode_q));
  omc_far_side omc_far_side_i (.ref_clk(ref_clk), .rst(rst), .raise_src(raise_src), .load_en(load_en),
    .load_val(load_val), .flags(flags), .enables(enables), .stop_level(stop_level), .reset_low(reset_low),
    .irq(irq), .stop_pin(stop_pin), .reset_pin_n(reset_pin_n));

  // ==========================================================================
  // bus and observation tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // idle cycle after the strobe so back-to-back calls never drive req twice in one step
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge ref_clk);
    svc = int_service_req;
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    d = rdata_q;
    @(posedge ref_clk);
  endtask : rd
  // counts warm-up cycles, resume pulses and stop cycles; ends at a negedge
  task automatic warm_len();
    w = 0;
    r = 0;
    s = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      if (w == 0)
        wosc = osc;
      w += int'(mode_q === omc_pkg::m_warmup);
      r += int'(resume === 1'b1);
      s += int'(bank_select_lost === 1'b1);
      if (w > 0 && mode_q !== omc_pkg::m_warmup)
        break;
    end
  endtask : warm_len
  // counts resume and service pulses after an idle wake request
  task automatic watch();
    r = 0;
    s = 0;
    repeat (6)
    begin
      @(negedge ref_clk);
      r += int'(resume === 1'b1);
      s += int'(int_service_req === 1'b1);
    end
    @(negedge ref_clk);
    `CHK("idle_exit", {1'b0, omc_pkg::m_fast_only_run}, {cpu_halt, mode_q})
    @(posedge ref_clk);
  endtask : watch
  // idle from the present run mode, woken by external interrupt zero
  task automatic doze(input logic [7:0] v, input omc_pkg::omc_mode_t md, input omc_pkg::omc_mode_t mr);
    wr(omc_pkg::ADDR_CTRL_TWO, v);
    @(negedge ref_clk);
    `CHK("doze", md, mode_q)
    @(posedge ref_clk);
    flags <= 3'b001;
    cyc(3);
    flags <= 3'b000;
    @(negedge ref_clk);
    `CHK("doze_exit", mr, mode_q)
    @(posedge ref_clk);
  endtask : doze
  task automatic pin_reset();
    reset_low <= 1'b1;
    cyc(5);
    @(negedge ref_clk);
    `CHK("chip_reset", 1'b1, chip_reset)
    @(posedge ref_clk);
    reset_low <= 1'b0;
    cyc(5);
    @(negedge ref_clk);
    `CHK("after_reset", {1'b0, omc_pkg::m_fast_only_run}, {cpu_halt, mode_q})
    @(posedge ref_clk);
  endtask : pin_reset
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ==========================================================================
  // clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    {req, raise_src, load_en, load_val, enables, flags, stop_level, reset_low} <= '0;
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(omc_pkg::ADDR_CTRL_ONE);
    `CHK("ctrl_one", 8'h00, d)
    rd(omc_pkg::ADDR_CTRL_TWO);
    `CHK("ctrl_two", 8'h80, d)
    wr(2'h3, 8'hff);
    rd(2'h3);
    `CHK("unmapped", 8'h00, d)
    // edge-style stop: long warm-up with pin low, short warm-up with pin already high
    for (int k = 0; k < 2; k++)
    begin
      stop_level <= k[0];
      cyc(4);
      wr(omc_pkg::ADDR_CTRL_ONE, k ? 8'h84 : 8'h80);
      cyc(3);
      @(negedge ref_clk);
      `CHK("stop", 8'hf0, {cpu_halt, periph_halt, port_hiz, bank_select_lost, osc, |timing_div_q})
      @(posedge ref_clk);
      stop_level <= 1'b0;
      cyc(4);
      stop_level <= 1'b1;
      warm_len();
      `CHK("warm_fast", k ? FS : FL, w)
      `CHK("resume", 1, r)
      @(posedge ref_clk);
    end
    // dual clock, slow return, port drive kept
    wr(omc_pkg::ADDR_CTRL_TWO, 8'hc0);
    stop_level <= 1'b0;
    cyc(4);
    wr(omc_pkg::ADDR_CTRL_ONE, 8'hb4);
    cyc(3);
    @(negedge ref_clk);
    `CHK("stop_dual", {1'b0, omc_pkg::m_halt_variant_b}, {port_hiz, mode_q})
    @(posedge ref_clk);
    stop_level <= 1'b1;
    warm_len();
    `CHK("warm_slow", 1'b1, w > (SS - 1) * DV && w <= SS * DV)
    `CHK("slow_osc", 2'b01, {wosc.fast_run, wosc.slow_run})
    `CHK("slow_mode", {1'b1, omc_pkg::m_slow_run}, {osc.cpu_on_slow, mode_q})
    @(posedge ref_clk);
    wr(omc_pkg::ADDR_CTRL_ONE, 8'hb4);
    cyc(3);
    pin_reset();
    // level style waits for a rising edge, then a high pin skips the stop
    stop_level <= 1'b0;
    wr(omc_pkg::ADDR_CTRL_ONE, 8'h40);
    rd(omc_pkg::ADDR_STATUS);
    `CHK("level_pend", 2'b01, d[7:6])
    stop_level <= 1'b1;
    cyc(5);
    rd(omc_pkg::ADDR_STATUS);
    `CHK("level_eff", 2'b10, d[7:6])
    wr(omc_pkg::ADDR_CTRL_ONE, 8'hc4);
    warm_len();
    `CHK("level_skip", {FS, 32'h0}, {w, s})
    @(posedge ref_clk);
    stop_level <= 1'b0;
    cyc(4);
    wr(omc_pkg::ADDR_CTRL_ONE, 8'hc4);
    cyc(2);
    stop_level <= 1'b1;
    warm_len();
    `CHK("level_wake", 1'b1, w == FS && s > 0)
    @(posedge ref_clk);
    // idle with master flag low, then high, then blocked by a watchdog request
    enables <= 12'h001;
    wr(omc_pkg::ADDR_CTRL_TWO, 8'h90);
    @(negedge ref_clk);
    `CHK("idle", {3'b110, omc_pkg::m_fast_only_doze}, {cpu_halt, wdt_halt, periph_halt, mode_q})
    @(posedge ref_clk);
    raise_src <= 12'h001;
    @(posedge ref_clk);
    raise_src <= 12'h000;
    watch();
    `CHK("wake_plain", {32'h1, 32'h0}, {r, s})
    {load_en, load_val} <= {1'b1, 12'hffe};
    @(posedge ref_clk);
    {load_en, flags} <= {1'b0, 3'b100};
    wr(omc_pkg::ADDR_CTRL_TWO, 8'h90);
    flags <= 3'b101;
    watch();
    `CHK("wake_service", {32'h0, 32'h1}, {r, s})
    flags <= 3'b110;
    wr(omc_pkg::ADDR_CTRL_TWO, 8'h90);
    @(negedge ref_clk);
    `CHK("wdt_block", 2'b10, {svc, cpu_halt})
    @(posedge ref_clk);
    flags <= 3'b000;
    wr(omc_pkg::ADDR_CTRL_TWO, 8'h90);
    pin_reset();
    // slow and back: cpu stays on slow clock until the switch-over
    wr(omc_pkg::ADDR_CTRL_TWO, 8'hc0);
    doze(8'hd0, omc_pkg::m_dual_clock_doze, omc_pkg::m_dual_clock_run);
    wr(omc_pkg::ADDR_CTRL_TWO, 8'he0);
    wr(omc_pkg::ADDR_CTRL_TWO, 8'h60);
    cyc(2 * DV);
    @(negedge ref_clk);
    `CHK("slow_run", 3'b011, osc)
    @(posedge ref_clk);
    doze(8'h70, omc_pkg::m_sleep_doze, omc_pkg::m_slow_run);
    wr(omc_pkg::ADDR_CTRL_TWO, 8'he0);
    cyc(2 * DV);
    req <= '{wr: 1'b1, rd: 1'b0, addr: omc_pkg::ADDR_CTRL_TWO, wdata: 8'hc0};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    `CHK("still_slow", 1'b1, osc.cpu_on_slow)
    cyc(2 * DV);
    @(negedge ref_clk);
    `CHK("now_fast", 1'b0, osc.cpu_on_slow)
    close_out();
  end
endmodule : omc_mode_ctrl_test

`default_nettype wire
